// ===== cfg_regs_sva.sv
// port-level assertions for the port configuration bank
`default_nettype none
module cfg_regs_sva
   import usb_phy_pkg::*;
(
   // watched ports
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic pcie_resetn_in,
   input wire logic global_reset_in,
   input wire logic cfg_req_in,
   input wire logic cfg_write_in,
   input wire usb_phy_pkg::cfg_addr_t cfg_addr_in,
   input wire usb_phy_pkg::cfg_word_t cfg_rdata_out,
   input wire logic cfg_ack_out,
   input wire logic [3:0] hs_removable_in,
   input wire logic [3:0] hs_removable_out,
   input wire logic [15:0] tx_amplitude_out,
   input wire logic [15:0] rx_eq_operating_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import usb_phy_pkg::*;
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!resetn_in);
   logic rd;
   assign rd = cfg_req_in && !cfg_write_in;
   a_ack_follows: assert property (cfg_req_in |=> cfg_ack_out) else $error("ack missing");
   a_ack_no_req: assert property (!cfg_req_in |=> !cfg_ack_out) else $error("ack without request");
   a_rdata_hold: assert property (!rd |=> $stable(cfg_rdata_out)) else $error("read data moved");
   a_unmapped_zero: assert property (rd && !(cfg_addr_in inside {8'he0, 8'he4, 8'he8, 8'hec})
      |=> cfg_rdata_out == 32'h00000000) else $error("unmapped read not zero");
   a_fixed_mask: assert property (rd && cfg_addr_in == 8'he0 |=> cfg_rdata_out[31:8] == 24'h000000)
      else $error("port control upper bits set");
   a_override_mask: assert property (rd && cfg_addr_in == 8'hec |=> (cfg_rdata_out & 32'hf8f8f8f8) == 32'h0)
      else $error("override reserved bits set");
   // first edge after reset still sees the output's reset value, so it is skipped
   a_removable_pass: assert property ($past(resetn_in) |-> (hs_removable_out | ~$past(hs_removable_in)) == 4'hf)
      else $error("removable flag lost");
   a_clear_defaults: assert property ((!pcie_resetn_in || global_reset_in) [*5]
      |-> tx_amplitude_out == 16'h0000 && rx_eq_operating_out == 16'h0000) else $error("clear left overrides");
   cover property (rd && cfg_addr_in == 8'he4);
   cover property (!pcie_resetn_in [*5]);
   cover property (global_reset_in [*5]);
endmodule
`default_nettype wire

// ===== phy_port_select.sv
// per-port choice between override fields and built-in defaults
`default_nettype none
module phy_port_select
   import usb_phy_pkg::*;
(
   // clock and clear
   input wire logic clk_sys_in,
   input wire logic clear_in,
   // controls
   input wire logic present_in,
   input wire logic amp_ovr_in,
   input wire logic emph_ovr_in,
   input wire logic eq_ovr_in,
   // fields and defaults
   input wire usb_phy_pkg::phy_field_t amp_field_in,
   input wire usb_phy_pkg::phy_field_t emph_field_in,
   input wire usb_phy_pkg::phy_field_t eq_train_field_in,
   input wire usb_phy_pkg::phy_field_t eq_oper_field_in,
   input wire usb_phy_pkg::phy_field_t amp_default_in,
   input wire usb_phy_pkg::phy_field_t emph_default_in,
   input wire usb_phy_pkg::phy_field_t eq_train_default_in,
   input wire usb_phy_pkg::phy_field_t eq_oper_default_in,
   // settings to the phy
   output var usb_phy_pkg::phy_field_t amp_out,
   output var usb_phy_pkg::phy_field_t emph_out,
   output var usb_phy_pkg::phy_field_t eq_train_out,
   output var usb_phy_pkg::phy_field_t eq_oper_out
);
   import usb_phy_pkg::*;

   // an absent port keeps its defaults whatever the fields hold
   always_ff @(posedge clk_sys_in)
   begin
      if (clear_in)
      begin
         amp_out <= amp_default_in;
         emph_out <= emph_default_in;
         eq_train_out <= eq_train_default_in;
         eq_oper_out <= eq_oper_default_in;
      end
      else
      begin
         amp_out <= (present_in && amp_ovr_in) ? amp_field_in : amp_default_in;
         emph_out <= (present_in && emph_ovr_in) ? emph_field_in : emph_default_in;
         eq_train_out <= (present_in && eq_ovr_in) ? eq_train_field_in : eq_train_default_in;
         eq_oper_out <= (present_in && eq_ovr_in) ? eq_oper_field_in : eq_oper_default_in;
      end
   end
endmodule
`default_nettype wire

// ===== usb_phy_cfg.svh
// register offsets, field positions and reset values of the port configuration bank
// Contract
// - superspeed fixed bits 7:4 force removable flag
// - high-speed fixed bits 3:0 force removable flag
// - two-port variant: ports 3,4 bits inert
// - all fields cleared by any reset
// - swing/emphasis register at e4h, resets zero
// - port 4 amplitude from bits 31:28
// - port 4 emphasis from bits 27:24
// - port 3 amplitude 23:20, emphasis 19:16
// - port 2 amplitude 15:12, emphasis 11:8
// - port 1 amplitude 7:4, emphasis 3:0
// - two-port variant: ports 3,4 fields inert
// - equalizer register at e8h, resets zero
// - per-port override bits; port 4 26,25,24
// - equalizer training/operating fields per port
`ifndef USB_PHY_CFG_SVH
`define USB_PHY_CFG_SVH
`define CFG_OFS_PORT_CONTROL 8'he0
`define CFG_OFS_TX_OVERRIDE 8'he4
`define CFG_OFS_RX_EQ_OVERRIDE 8'he8
`define CFG_OFS_OVERRIDE_ENABLE 8'hec
`define CFG_RESET_VALUE 32'h00000000
`define CFG_SS_FIXED_LSB 4
`define CFG_HS_FIXED_LSB 0
`define CFG_FIXED_MASK 32'h000000ff
`define CFG_OVERRIDE_MASK 32'h07070707
`define CFG_PORT_STRIDE 8
`define CFG_UPPER_FIELD_LSB 4
`define CFG_LOWER_FIELD_LSB 0
`define CFG_OVR_EMPHASIS_BIT 0
`define CFG_OVR_AMPLITUDE_BIT 1
`define CFG_OVR_EQ_BIT 2
`endif

// ===== usb_phy_pkg.sv
// types shared by the port configuration bank
`default_nettype none
package usb_phy_pkg;
   typedef logic [3:0] phy_field_t;
   typedef logic [31:0] cfg_word_t;
   typedef logic [7:0] cfg_addr_t;
endpackage
`default_nettype wire

// ===== usb_port_phy_config_regs.sv
// configuration-space register bank for downstream port removability and phy overrides
`default_nettype none
`include "usb_phy_cfg.svh"
module usb_port_phy_config_regs
   import usb_phy_pkg::*;
#(
   parameter int NUM_PORTS = 4,
   parameter logic [15:0] AMP_DEFAULTS = 16'h0000,
   parameter logic [15:0] EMPH_DEFAULTS = 16'h0000,
   parameter logic [15:0] EQ_TRAIN_DEFAULTS = 16'h0000,
   parameter logic [15:0] EQ_OPER_DEFAULTS = 16'h0000
)
(
   // clock and resets
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic pcie_resetn_in,
   input wire logic global_reset_in,
   // configuration access
   input wire logic cfg_req_in,
   input wire logic cfg_write_in,
   input wire usb_phy_pkg::cfg_addr_t cfg_addr_in,
   input wire logic [3:0] cfg_be_in,
   input wire usb_phy_pkg::cfg_word_t cfg_wdata_in,
   output var usb_phy_pkg::cfg_word_t cfg_rdata_out,
   output logic cfg_ack_out,
   // removable flags from the port status logic
   input wire logic [3:0] ss_removable_in,
   input wire logic [3:0] hs_removable_in,
   output var logic [3:0] ss_removable_out,
   output var logic [3:0] hs_removable_out,
   // phy settings, port 1 in bits 3:0
   output var logic [15:0] tx_amplitude_out,
   output var logic [15:0] tx_emphasis_out,
   output var logic [15:0] rx_eq_training_out,
   output var logic [15:0] rx_eq_operating_out
);
   import usb_phy_pkg::*;

   // synchronised reset pins
   logic pcie_meta_q;
   logic pcie_sync_q;
   logic global_reset_in_meta_q;
   logic global_reset_in_sync_q;
   logic clear;
   // register words
   cfg_word_t port_control_q;
   cfg_word_t tx_override_q;
   cfg_word_t rx_eq_override_q;
   cfg_word_t override_enable_q;
   logic ack_q;
   logic [3:0] present;

   // request decode
   logic rd_req;
   logic [3:0] wr_hit;
   logic [3:0] rd_hit;
   cfg_word_t rdata_d;

   function automatic cfg_word_t merge_bytes(input cfg_word_t old_w, input cfg_word_t new_w,
                                             input logic [3:0] be, input cfg_word_t mask);
      cfg_word_t res;
      res = old_w;
      for (int b = 0; b < 4; b++)
      begin
         if (be[b])
         begin
            res[b*8 +: 8] = new_w[b*8 +: 8];
         end
      end
      return res & mask;
   endfunction

   // one-hot choice of the mapped word; the write and the read path share it
   function automatic logic [3:0] decode_offset(input cfg_addr_t addr);
      logic [3:0] hit;
      hit = 4'h0;
      unique case (addr)
         `CFG_OFS_PORT_CONTROL:
         begin
            hit[0] = 1'b1;
         end
         `CFG_OFS_TX_OVERRIDE:
         begin
            hit[1] = 1'b1;
         end
         `CFG_OFS_RX_EQ_OVERRIDE:
         begin
            hit[2] = 1'b1;
         end
         `CFG_OFS_OVERRIDE_ENABLE:
         begin
            hit[3] = 1'b1;
         end
         default:
         begin
            hit = 4'h0;
         end
      endcase
      return hit;
   endfunction

   // a fixed bit only forces the flag on a port that is fitted
   function automatic logic force_removable(input logic raw, input logic fitted, input logic fixed);
      return raw | (fitted & fixed);
   endfunction

   // reset pins come from outside the clock domain; the bank stays clear until both have settled
   always_ff @(posedge clk_sys_in)
   begin
      if (!resetn_in)
      begin
         pcie_meta_q <= 1'b0;
         pcie_sync_q <= 1'b0;
      end
      else
      begin
         pcie_meta_q <= pcie_resetn_in;
         pcie_sync_q <= pcie_meta_q;
      end
   end

   // the global reset pin is active high, so its flops rest at one
   always_ff @(posedge clk_sys_in)
   begin
      if (!resetn_in)
      begin
         global_reset_in_meta_q <= 1'b1;
         global_reset_in_sync_q <= 1'b1;
      end
      else
      begin
         global_reset_in_meta_q <= global_reset_in;
         global_reset_in_sync_q <= global_reset_in_meta_q;
      end
   end

   // the bank clears while the chip reset or either synchronised pin asks for it;
   // a pin pulse shorter than one clock may be missed
   assign clear = !resetn_in || !pcie_sync_q || global_reset_in_sync_q;

   // a request hits at most one word; unmapped offsets hit none
   assign rd_req = cfg_req_in && !cfg_write_in;
   assign wr_hit = (cfg_req_in && cfg_write_in) ? decode_offset(cfg_addr_in) : 4'h0;
   assign rd_hit = rd_req ? decode_offset(cfg_addr_in) : 4'h0;

   // writes are ignored while any reset holds the bank clear
   // only the fixed bits of this word are built; its control fields read zero
   always_ff @(posedge clk_sys_in)
   begin
      if (clear)
      begin
         port_control_q <= `CFG_RESET_VALUE;
      end
      else if (wr_hit[0])
      begin
         port_control_q <= merge_bytes(port_control_q, cfg_wdata_in, cfg_be_in, `CFG_FIXED_MASK);
      end
   end

   // transmit fields only act once the matching override bit is set
   always_ff @(posedge clk_sys_in)
   begin
      if (clear)
      begin
         tx_override_q <= `CFG_RESET_VALUE;
      end
      else if (wr_hit[1])
      begin
         tx_override_q <= merge_bytes(tx_override_q, cfg_wdata_in, cfg_be_in, 32'hffffffff);
      end
   end

   // equalizer fields only act once the port's equalizer override bit is set
   always_ff @(posedge clk_sys_in)
   begin
      if (clear)
      begin
         rx_eq_override_q <= `CFG_RESET_VALUE;
      end
      else if (wr_hit[2])
      begin
         rx_eq_override_q <= merge_bytes(rx_eq_override_q, cfg_wdata_in, cfg_be_in, 32'hffffffff);
      end
   end

   // reserved bits are masked on the way in so they always read zero
   always_ff @(posedge clk_sys_in)
   begin
      if (clear)
      begin
         override_enable_q <= `CFG_RESET_VALUE;
      end
      else if (wr_hit[3])
      begin
         override_enable_q <= merge_bytes(override_enable_q, cfg_wdata_in, cfg_be_in,
                                          `CFG_OVERRIDE_MASK);
      end
   end

   // unmapped offsets read zero
   always_comb
   begin
      rdata_d = 32'h00000000;
      if (rd_hit[0])
      begin
         rdata_d = port_control_q;
      end
      if (rd_hit[1])
      begin
         rdata_d = tx_override_q;
      end
      if (rd_hit[2])
      begin
         rdata_d = rx_eq_override_q;
      end
      if (rd_hit[3])
      begin
         rdata_d = override_enable_q;
      end
   end

   // read data holds until the next read, so a slow reader still finds it
   always_ff @(posedge clk_sys_in)
   begin
      if (!resetn_in)
      begin
         cfg_rdata_out <= 32'h00000000;
      end
      else if (rd_req)
      begin
         cfg_rdata_out <= rdata_d;
      end
   end

   // one-cycle answer to every request, writes during a clear included
   always_ff @(posedge clk_sys_in)
   begin
      if (!resetn_in)
      begin
         ack_q <= 1'b0;
      end
      else
      begin
         ack_q <= cfg_req_in;
      end
   end

   assign cfg_ack_out = ack_q;

   // ports above NUM_PORTS keep their storage but steer nothing
   genvar p;
   generate
      for (p = 0; p < 4; p++)
      begin : g_port
         assign present[p] = (p < NUM_PORTS);

         // the fixed bit can only force the flag on; the raw flag still passes through
         always_ff @(posedge clk_sys_in)
         begin
            if (!resetn_in)
            begin
               ss_removable_out[p] <= 1'b0;
            end
            else
            begin
               ss_removable_out[p] <= force_removable(ss_removable_in[p], present[p],
                                                      port_control_q[`CFG_SS_FIXED_LSB + p]);
            end
         end

         always_ff @(posedge clk_sys_in)
         begin
            if (!resetn_in)
            begin
               hs_removable_out[p] <= 1'b0;
            end
            else
            begin
               hs_removable_out[p] <= force_removable(hs_removable_in[p], present[p],
                                                      port_control_q[`CFG_HS_FIXED_LSB + p]);
            end
         end

         phy_port_select u_sel (
            .clk_sys_in(clk_sys_in),
            .clear_in(clear),
            .present_in(present[p]),
            .amp_ovr_in(override_enable_q[p*`CFG_PORT_STRIDE + `CFG_OVR_AMPLITUDE_BIT]),
            .emph_ovr_in(override_enable_q[p*`CFG_PORT_STRIDE + `CFG_OVR_EMPHASIS_BIT]),
            .eq_ovr_in(override_enable_q[p*`CFG_PORT_STRIDE + `CFG_OVR_EQ_BIT]),
            .amp_field_in(tx_override_q[p*`CFG_PORT_STRIDE + `CFG_UPPER_FIELD_LSB +: 4]),
            .emph_field_in(tx_override_q[p*`CFG_PORT_STRIDE + `CFG_LOWER_FIELD_LSB +: 4]),
            .eq_train_field_in(rx_eq_override_q[p*`CFG_PORT_STRIDE + `CFG_UPPER_FIELD_LSB +: 4]),
            .eq_oper_field_in(rx_eq_override_q[p*`CFG_PORT_STRIDE + `CFG_LOWER_FIELD_LSB +: 4]),
            .amp_default_in(AMP_DEFAULTS[p*4 +: 4]),
            .emph_default_in(EMPH_DEFAULTS[p*4 +: 4]),
            .eq_train_default_in(EQ_TRAIN_DEFAULTS[p*4 +: 4]),
            .eq_oper_default_in(EQ_OPER_DEFAULTS[p*4 +: 4]),
            .amp_out(tx_amplitude_out[p*4 +: 4]),
            .emph_out(tx_emphasis_out[p*4 +: 4]),
            .eq_train_out(rx_eq_training_out[p*4 +: 4]),
            .eq_oper_out(rx_eq_operating_out[p*4 +: 4])
         );
      end
   endgenerate
endmodule
`default_nettype wire

// ===== usb_port_phy_config_regs_tb.sv
// self-checking bench for the port configuration bank
`default_nettype none
module usb_port_phy_config_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import usb_phy_pkg::*;
   logic clk_sys_in = '0, resetn_in = '0, pcie_resetn_in = 1'b1, global_reset_in = '0, cfg_req_in = '0;
   logic cfg_write_in = '0, cfg_ack_out;
   logic [1:0] taken_q = '0;
   cfg_addr_t cfg_addr_in = '0;
   logic [3:0] cfg_be_in = '0, ss_removable_in = '0, hs_removable_in = '0, ss_removable_out, hs_removable_out;
   cfg_word_t cfg_wdata_in = '0, cfg_rdata_out, seed = 32'h9125d6de, sh[4], exp_q[$];
   logic [15:0] tx_amplitude_out, tx_emphasis_out, rx_eq_training_out, rx_eq_operating_out, e[4];
   int num_errors = 0, num_checks = 0;
   logic ack_two;
   cfg_word_t rdata_two, rd_x;
   logic [3:0] ss_two, hs_two;
   logic [15:0] amp_two, emph_two, train_two, oper_two;
   localparam cfg_word_t rmask[4] = '{32'h000000ff, 32'hffffffff, 32'hffffffff, 32'h07070707};
   usb_port_phy_config_regs DUT (.*);
   // second bank built as the two-port variant, fed the same requests
   usb_port_phy_config_regs #(.NUM_PORTS(2)) dut_two_port (
      .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .pcie_resetn_in(pcie_resetn_in),
      .global_reset_in(global_reset_in), .cfg_req_in(cfg_req_in), .cfg_write_in(cfg_write_in),
      .cfg_addr_in(cfg_addr_in), .cfg_be_in(cfg_be_in), .cfg_wdata_in(cfg_wdata_in),
      .cfg_rdata_out(rdata_two), .cfg_ack_out(ack_two), .ss_removable_in(ss_removable_in),
      .hs_removable_in(hs_removable_in), .ss_removable_out(ss_two), .hs_removable_out(hs_two),
      .tx_amplitude_out(amp_two), .tx_emphasis_out(emph_two), .rx_eq_training_out(train_two),
      .rx_eq_operating_out(oper_two));
   always #12.5 clk_sys_in = ~clk_sys_in;
   function automatic cfg_word_t lfsr(cfg_word_t v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic check(string what, logic [31:0] seen, logic [31:0] x);
      num_checks++;
      if (seen !== x)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, x, seen);
      end
   endtask
   // one request per cycle; the caller releases the request line
   task automatic acc(logic wr, int a, logic [3:0] be, cfg_word_t x);
      cfg_word_t m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      seed = lfsr(seed);
      cfg_req_in = 1'b1;
      cfg_write_in = wr;
      cfg_addr_in = 8'he0 + 8'(4 * a);
      cfg_be_in = be;
      cfg_wdata_in = seed;
      if (!wr)
         exp_q.push_back(x);
      else if (a < 4)
         sh[a] = (sh[a] & ~m) | (seed & m & rmask[a]);
      @(negedge clk_sys_in);
   endtask
   task automatic rd_all;
      for (int a = 0; a < 5; a++)
         acc(1'b0, a, 4'h0, a < 4 ? sh[a] : 32'h0);
      cfg_req_in = 1'b0;
      @(negedge clk_sys_in);
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge clk_sys_in)
      taken_q <= {cfg_req_in, cfg_req_in && !cfg_write_in};
   always @(negedge clk_sys_in)
      if (taken_q[1])
      begin
         check("ack", cfg_ack_out, 32'h1);
         check("two-port ack", ack_two, 32'h1);
         if (taken_q[0])
         begin
            rd_x = exp_q.pop_front();
            check("read data", cfg_rdata_out, rd_x);
            check("two-port read data", rdata_two, rd_x);
         end
      end
   initial
   begin
      repeat (2000) @(posedge clk_sys_in);
      num_errors++;
      end_of_test;
   end
   initial
   begin
      sh = '{default: '0};
      repeat (5) @(negedge clk_sys_in);
      resetn_in = 1'b1;
      rd_all;
      $display("reset values done");
      for (int r = 0; r < 6; r++)
      begin
         {ss_removable_in, hs_removable_in} = seed[7:0];
         for (int a = 0; a < 5; a++)
            acc(1'b1, a, seed[11:8], 32'h0);
         cfg_req_in = 1'b0;
         repeat (2) @(negedge clk_sys_in);
         for (int p = 0; p < 4; p++)
         begin
            e[0][4*p +: 4] = sh[3][8*p+1] ? sh[1][8*p+4 +: 4] : 4'h0;
            e[1][4*p +: 4] = sh[3][8*p] ? sh[1][8*p +: 4] : 4'h0;
            e[2][4*p +: 4] = sh[3][8*p+2] ? sh[2][8*p+4 +: 4] : 4'h0;
            e[3][4*p +: 4] = sh[3][8*p+2] ? sh[2][8*p +: 4] : 4'h0;
         end
         check("amplitude", tx_amplitude_out, e[0]);
         check("emphasis", tx_emphasis_out, e[1]);
         check("eq training", rx_eq_training_out, e[2]);
         check("eq operating", rx_eq_operating_out, e[3]);
         check("ss removable", ss_removable_out, ss_removable_in | sh[0][7:4]);
         check("hs removable", hs_removable_out, hs_removable_in | sh[0][3:0]);
         check("two-port amplitude", amp_two, {8'h00, e[0][7:0]});
         check("two-port emphasis", emph_two, {8'h00, e[1][7:0]});
         check("two-port eq", {train_two, oper_two}, {8'h00, e[2][7:0], 8'h00, e[3][7:0]});
         check("two-port ss removable", ss_two, ss_removable_in | {2'b00, sh[0][5:4]});
         check("two-port hs removable", hs_two, hs_removable_in | {2'b00, sh[0][1:0]});
         rd_all;
         // last two rounds clear the bank, first by the link reset, then by the global one
         if (r > 3)
         begin
            pcie_resetn_in = r[0];
            global_reset_in = r[0];
            repeat (3) @(negedge clk_sys_in);
            acc(1'b1, 1, 4'hf, 32'h0);
            cfg_req_in = 1'b0;
            repeat (3) @(negedge clk_sys_in);
            check("cleared amplitude", tx_amplitude_out, 16'h0000);
            check("two-port cleared amplitude", amp_two, 16'h0000);
            pcie_resetn_in = 1'b1;
            global_reset_in = 1'b0;
            repeat (3) @(negedge clk_sys_in);
            sh = '{default: '0};
            rd_all;
         end
         $display("round %0d done", r);
      end
      end_of_test;
   end
endmodule
bind usb_port_phy_config_regs cfg_regs_sva chk (.*);
`default_nettype wire
